/* bench/rtbl_master.sv */
// Purpose: write-side bus master model driving requests into rtbl_core
// Assumes: same clock as the slave; changes land 1 ns after the edge
// Notes:   idle data and strobes show the inverse of the last beat
`timescale 1ns/1ps
`default_nettype none

module rtbl_master (
    // clock
    input wire logic mclk,
    // write address channel
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] awaddr,
    output logic [7:0] awlen,
    output logic [2:0] awsize,
    output logic [1:0] awburst,
    // write data channel
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wlast,
    // write response channel
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp
);
    int wait_cnt;
    initial begin
        {awvalid, wvalid, wlast, bready} = 4'h0;
        {awaddr, awlen, awsize, awburst} = 45'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // request held until the ready edge, released 1 ns after it
    task automatic send_aw(input logic [31:0] a, input logic [7:0] l,
                           input logic [2:0] s, input logic [1:0] b);
        awvalid <= 1'b1;
        awaddr <= a;
        awlen <= l;
        awsize <= s;
        awburst <= b;
        wait_cnt = 0;
        do begin
            @(posedge mclk);
            wait_cnt++;
        end while (awready !== 1'b1 && wait_cnt < 200);
        #1 awvalid <= 1'b0;
    endtask
    // strobes chosen by the caller, lane-limited except on purpose
    task automatic send_w(input logic [31:0] d, input logic [3:0] st,
                          input logic last);
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= st;
        wlast <= last;
        wait_cnt = 0;
        do begin
            @(posedge mclk);
            wait_cnt++;
        end while (wready !== 1'b1 && wait_cnt < 200);
        #1;
        // valid stays up between beats of one burst
        if (last) begin
            wvalid <= 1'b0;
            wdata <= ~d;
            wstrb <= ~st;
        end
    endtask
    // response taken at the handshake edge
    task automatic take_b(output logic [1:0] r);
        bready <= 1'b1;
        wait_cnt = 0;
        do begin
            @(posedge mclk);
            wait_cnt++;
        end while (bvalid !== 1'b1 && wait_cnt < 200);
        r = bresp;
        #1 bready <= 1'b0;
    endtask
endmodule // rtbl_master

`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench for rtbl_core, decode judged by its flag
// Assumes: one regular-only and one open slave; 32-bit bus; fixed seed
// Notes:   expected beats are queued by the bench, popped by a monitor
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rtbl_pkg::*;
    logic mclk, rst_n, big_endian, beat_ready, stall, proto_err, strb_err;
    logic awvalid, awready, wvalid, wready, wlast, bvalid, bready;
    logic beat_valid, proto_err_o;
    logic [31:0] awaddr, wdata;
    logic [7:0] awlen;
    logic [2:0] awsize;
    logic [1:0] awburst, bresp, resp, bresp_o;
    logic [3:0] wstrb;
    rtbl_beat_type beat;
    rtbl_beat_type exp_q[$];
    rtbl_cmd_type cmd;
    int error_cnt, samples_checked, cycles, seed, w_taken;

    rtbl_core #(.REG_ONLY(1'b1)) uut (.mclk(mclk), .rst_n(rst_n),
        .big_endian(big_endian), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .wlast(wlast), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .beat_valid(beat_valid), .beat_ready(beat_ready), .beat(beat),
        .proto_err(proto_err), .strb_err(strb_err));
    // open slave on the same wires: property left at its default
    rtbl_core uut_open (.mclk(mclk), .rst_n(rst_n),
        .big_endian(big_endian), .awvalid(awvalid), .awready(),
        .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
        .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb),
        .wlast(wlast), .bvalid(), .bready(bready), .bresp(bresp_o),
        .beat_valid(), .beat_ready(beat_ready), .beat(),
        .proto_err(proto_err_o), .strb_err());
    rtbl_master mst (.mclk(mclk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .wlast(wlast), .bvalid(bvalid), .bready(bready), .bresp(bresp));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic bit exp_regular(logic [31:0] a, int l, int s, int b);
        int n = l + 1;
        int by = 1 << s;
        bit ok = (n == 1 || n == 2 || n == 4 || n == 8 || n == 16);
        ok &= (n == 1 || s == 2);
        ok &= (b == 1 || b == 2);
        if (b == 1) ok &= (a % (by * n) == 0);
        else ok &= (a % by == 0);
        return ok;
    endfunction
    // lanes from the address lane up to the end of the aligned slot
    function automatic logic [3:0] exp_mask(logic [31:0] a, int s);
        int by = 1 << s;
        int lo = a % 4;
        int hi = ((a / by) * by + by - 1) % 4;
        logic [3:0] m = 4'h0;
        for (int i = lo; i <= hi; i++) m[i] = 1'b1;
        return m;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic check(logic [67:0] got, logic [67:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one whole burst; bad adds a lane 0 strobe only on beats whose lane mask leaves lane 0 out, so it always lands outside the mask
    task automatic run(logic [31:0] a, int l, int s, logic [1:0] b,
                       logic be, bit bad);
        logic [31:0] cur, d, bound, w;
        logic [3:0] m, st, es;
        bit rg;
        int by = 1 << s;
        bound = (a / (by * (l + 1))) * (by * (l + 1));
        rg = exp_regular(a, l, s, b);
        cur = a;
        big_endian <= be;
        mst.send_aw(a, 8'(l), 3'(s), b);
        check(proto_err, !rg);
        check(proto_err_o, 1'b0);
        for (int i = 0; i <= l; i++) begin
            m = exp_mask(cur, s);
            w = $random(seed);
            d = w;
            st = (m & 4'($random(seed))) | (bad ? ~m & 4'h1 : 4'h0);
            es = st & m;
            if (be && s == 1) begin
                d = {d[23:16], d[31:24], d[7:0], d[15:8]};
                es = {es[2], es[3], es[0], es[1]};
            end else if (be && s == 2) begin
                d = {d[7:0], d[15:8], d[23:16], d[31:24]};
                es = {es[0], es[1], es[2], es[3]};
            end
            exp_q.push_back('{addr: cur, data: d, strb: es});
            mst.send_w(w, st, i == l);
            check(strb_err, bad);
            if (b != BURST_FIXED) cur = (cur / by) * by + by;
            if (b == BURST_WRAP && cur >= bound + by * (l + 1)) cur = bound;
        end
        mst.take_b(resp);
        check(resp, rg ? RESP_OKAY : RESP_SLVERR);
        check(bresp_o, RESP_OKAY);
    endtask
    // raw data is sent; the queue holds the byte order to be delivered
    ////////////////////////////////////////////////////////////////////////
    // monitor of delivered beats and of accepted write beats
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            end_of_test();
        end
        if (wvalid === 1'b1 && wready === 1'b1) w_taken++;
        if (beat_valid === 1'b1 && beat_ready === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(beat, exp_q.pop_front());
        end
        #1 beat_ready <= stall ? 1'b0 : 1'($random(seed));
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {error_cnt, samples_checked, cycles, w_taken} = 0;
        seed = 32'hcf41;
        {rst_n, big_endian, beat_ready, stall} = 4'h0;
        cmd = '0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        // random requests; decode judged by the flag and the response
        for (int i = 0; i < 120; i++) begin
            cmd.addr = 32'($random(seed)) & 32'hFF;
            cmd.len = 8'($random(seed)) & 8'h1F;
            cmd.size = 3'($unsigned($random(seed)) % 3);
            cmd.burst = 2'($random(seed));
            // wraps keep a power-of-two length, as the bus demands
            if (cmd.burst == BURST_WRAP)
                cmd.len = 8'((2 << (cmd.len % 4)) - 1);
            run(cmd.addr, cmd.len, cmd.size, cmd.burst, 1'($random(seed)),
                0);
        end
        // hand-written corner cases
        run(32'h0, 4, 0, BURST_INCR, 1'b0, 0);
        run(32'h2, 3, 0, BURST_FIXED, 1'b0, 0);
        run(32'h4, 3, 2, BURST_WRAP, 1'b0, 0);
        run(32'h1, 3, 2, BURST_INCR, 1'b0, 0);
        run(32'h10, 1, 2, BURST_INCR, 1'b1, 0);
        run(32'h20, 3, 1, BURST_INCR, 1'b1, 0);
        run(32'h41, 0, 0, BURST_INCR, 1'b1, 0);
        run(32'h3, 0, 0, BURST_INCR, 1'b0, 1);
        run(32'h50, 0, 2, 2'h3, 1'b0, 0);
        for (int i = 0; i < 6; i++)
            run($random(seed) & 32'hF0, (2 << (i % 4)) - 1,
                2, 2'(1 + (i % 2)), 1'($random(seed)), 0);
        // fill the buffer with the far side stalled, starting empty
        while (exp_q.size() != 0) @(posedge mclk);
        stall = 1'b1;
        w_taken = 0;
        fork
            run(32'h100, 15, 2, BURST_INCR, 1'b0, 0);
            begin
                repeat (60) @(posedge mclk);
                check(w_taken, FIFO_DEPTH + 1);
                stall = 1'b0;
            end
        join
        repeat (40) @(posedge mclk);
        check(exp_q.size(), 0);
        end_of_test();
    end
endmodule // tb

`default_nettype wire

/* design/rtbl_classify.sv */
// Purpose: decides whether an address-channel request is Regular
// Assumes: 32-bit data bus
// Notes:   purely combinational, no state
`timescale 1ns/1ps
`default_nettype none

module rtbl_classify (
    // request under test
    input wire rtbl_pkg::rtbl_cmd_type cmd,
    // verdict
    output logic regular
);
    import rtbl_pkg::*;

    logic len_ok;
    logic size_ok;
    logic burst_ok;
    logic align_ok;
    logic [ADDR_W-1:0] container;

    ////////////////////////////////////////////////////////////////////
    // each criterion on its own, then all of them together
    always_comb begin
        len_ok = (cmd.len == 8'h00) || (cmd.len == 8'h01) ||
                 (cmd.len == 8'h03) || (cmd.len == 8'h07) ||
                 (cmd.len == 8'h0F); // R1
        size_ok = (cmd.len == 8'h00) || (cmd.size == BUS_SIZE); // R2
        burst_ok = (cmd.burst == BURST_INCR) ||
                   (cmd.burst == BURST_WRAP); // R3 R19
        container = ADDR_W'(({24'h0, cmd.len} + 32'h1) << cmd.size); // R20
        if (cmd.burst == BURST_WRAP) begin
            align_ok = ((cmd.addr & ADDR_W'((32'h1 << cmd.size) - 1))
                        == '0); // R4
        end else begin
            align_ok = ((cmd.addr & (container - 1'b1)) == '0); // R4
        end
        regular = len_ok && size_ok && burst_ok && align_ok;
    end

endmodule // rtbl_classify

`default_nettype wire

/* design/rtbl_core.sv */
// Purpose: write-side slave that classifies requests, steers byte lanes
//          per beat, converts byte order and buffers beats
// Assumes: master on the same clock; config inputs are synchronous
// Notes:   one burst in flight; beats leave through a FIFO of 8 array words plus a head word
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Regular needs burst length of 1, 2, 4, 8 or 16 transfers.
// R2: multi-beat Regular bursts must use full bus width transfers.
// R3: fixed bursts are never Regular; only incrementing or wrapping.
// R4: incr start aligned to container; wrap start aligned to size.
// R5: regular-only set means only Regular requests are supported.
// R6: regular-only clear means every legal request is accepted cleanly.
// R7: an undeclared regular-only property counts as false.
// R8: non-Regular request to regular-only slave is flagged as unsafe.
// R9: regular-only slave may decode only the Regular subset.
// R10: strobe bit n qualifies data byte lane n.
// R11: master raises strobes only on lanes holding valid data.
// R12: strobes are don't-care while write-valid is low.
// R13: narrow incr or wrap beats move across lanes with the address.
// R14: narrow fixed bursts use the same lanes on every beat.
// R15: a byte access always rides the same eight wires.
// R16: endianness only reorders bytes inside an element's own bytes.
// R17: single-width path wires lanes straight through.
// R18: big-endian users get a byte-reordering stage.
// R19: burst code 00 fixed, 01 incrementing, 10 wrapping, 11 reserved.
// R20: container is bytes times length from aligned start or boundary.
// R21: later beats: low lane is address mod lanes, plus size minus one.
// R22: regular-only slave flags any accepted non-Regular request.
module rtbl_core #(
    parameter bit REG_ONLY = 1'b0 // R7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration
    input wire logic big_endian,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [rtbl_pkg::ADDR_W-1:0] awaddr,
    input wire logic [rtbl_pkg::LEN_W-1:0] awlen,
    input wire logic [2:0] awsize,
    input wire logic [1:0] awburst,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [rtbl_pkg::DATA_W-1:0] wdata,
    input wire logic [rtbl_pkg::LANES-1:0] wstrb,
    input wire logic wlast,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // local side beats
    output logic beat_valid,
    input wire logic beat_ready,
    output rtbl_pkg::rtbl_beat_type beat,
    // indications
    output logic proto_err,
    output logic strb_err
);
    import rtbl_pkg::*;

    rtbl_state_type state_q;
    rtbl_state_type state_d;
    rtbl_cmd_type aw_in;
    rtbl_cmd_type cmd_q;
    rtbl_beat_type push_beat;
    logic aw_regular;
    logic aw_fire;
    logic w_fire;
    logic last_beat;
    logic fifo_in_ready;
    logic bad_q;
    logic proto_err_q;
    logic strb_err_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [LEN_W-1:0] beat_q;
    logic [LANES-1:0] cur_mask;
    logic [ADDR_W-1:0] nbytes;
    logic [ADDR_W-1:0] container;
    logic [ADDR_W-1:0] aligned;

    ////////////////////////////////////////////////////////////////////
    // request classification
    assign aw_in = '{addr: awaddr, len: awlen, size: awsize,
                     burst: awburst};

    rtbl_classify u_classify (
        .cmd (aw_in),
        .regular (aw_regular)
    );

    // wlast is left unread: the count from awlen ends the burst, so a
    // misplaced wlast can neither cut a burst short nor stretch it
    // handshakes; data stalls when the FIFO is full
    assign awready = (state_q == ST_IDLE);
    assign aw_fire = awvalid && awready;
    assign wready = (state_q == ST_DATA) && fifo_in_ready;
    assign w_fire = wvalid && wready; // R12
    assign last_beat = (beat_q == cmd_q.len);
    assign bvalid = (state_q == ST_RESP);
    assign bresp = bad_q ? RESP_SLVERR : RESP_OKAY; // R5
    assign proto_err = proto_err_q;
    assign strb_err = strb_err_q;

    ////////////////////////////////////////////////////////////////////
    // burst sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (aw_fire) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (w_fire && last_beat) begin
                    state_d = ST_RESP;
                end
            end
            ST_RESP: begin
                if (bready) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // beat address: generic decode kept even when regular-only, since
    // the saving is tiny and a stray request still walks sanely
    always_comb begin
        nbytes = ADDR_W'(32'h1 << cmd_q.size);
        container = ADDR_W'(({24'h0, cmd_q.len} + 32'h1)
                             << cmd_q.size); // R20 R9
        aligned = addr_q & ~(nbytes - 1'b1);
        addr_d = aligned + nbytes; // R13
        if (cmd_q.burst == BURST_FIXED) begin
            addr_d = addr_q; // R14
        end else if (cmd_q.burst == BURST_WRAP &&
                     ((addr_d & (container - 1'b1)) == '0)) begin
            addr_d = addr_d - container; // R20
        end
    end

    // command capture and beat walking
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= '0;
            addr_q <= '0;
            beat_q <= '0;
        end else if (aw_fire) begin
            cmd_q <= aw_in;
            addr_q <= awaddr;
            beat_q <= '0;
        end else if (w_fire) begin
            addr_q <= addr_d;
            beat_q <= LEN_W'(beat_q + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // violation flags: regular-only slave reports non-Regular requests
    // bad_q holds until the next request, so bresp stands until taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bad_q <= 1'b0;
            proto_err_q <= 1'b0;
        end else begin
            proto_err_q <= aw_fire && REG_ONLY && !aw_regular; // R22 R8
            if (aw_fire) begin
                bad_q <= REG_ONLY && !aw_regular; // R5 R6
            end
        end
    end

    // strobe on a lane the address does not select: master's fault
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strb_err_q <= 1'b0;
        end else begin
            strb_err_q <= w_fire && ((wstrb & ~cur_mask) != '0); // R11
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lane steering and byte order; little-endian goes straight through
    assign cur_mask = lane_mask(addr_q, cmd_q.size); // R21 R13 R14

    always_comb begin
        push_beat.addr = addr_q;
        push_beat.data = wdata; // R17 R15
        push_beat.strb = wstrb & cur_mask; // R10
        if (big_endian) begin
            push_beat.data = be_swap(wdata, cmd_q.size); // R18 R16
            push_beat.strb = be_swap_strb(wstrb & cur_mask,
                                          cmd_q.size); // R18
        end
    end

    // nine beats of slack (array plus head) ride out a short local stall
    rtbl_fifo #(
        .WIDTH ($bits(rtbl_beat_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk (mclk),
        .rst_n (rst_n),
        .in_valid (w_fire),
        .in_ready (fifo_in_ready),
        .in_data (push_beat),
        .out_valid (beat_valid),
        .out_ready (beat_ready),
        .out_data (beat)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_len_class: assert property ( // R1
        aw_fire && !(awlen inside {8'h00, 8'h01, 8'h03, 8'h07, 8'h0F})
        |-> !aw_regular)
        else $error("odd burst length classed regular");

    a_size_class: assert property ( // R2
        aw_fire && awlen != 8'h00 && awsize != BUS_SIZE |-> !aw_regular)
        else $error("narrow multi-beat burst classed regular");

    a_fixed_class: assert property ( // R3
        aw_fire && awburst == BURST_FIXED |-> !aw_regular)
        else $error("fixed burst classed regular");

    a_incr_align: assert property ( // R4
        aw_fire && awburst == BURST_INCR && awlen == 8'h03 &&
        awsize == BUS_SIZE && awaddr[3:0] != 4'h0 |-> !aw_regular)
        else $error("misaligned incr burst classed regular");

    a_nonreg_flag: assert property ( // R22
        aw_fire && !aw_regular |=> proto_err == REG_ONLY ##1 !proto_err)
        else $error("non-regular flag wrong or not one cycle");

    a_quiet_flag: assert property ( // R6
        !REG_ONLY |-> !proto_err && bresp == RESP_OKAY)
        else $error("flag raised while regular-only is off");

    a_fixed_lanes: assert property ( // R14
        w_fire && cmd_q.burst == BURST_FIXED && !last_beat
        |=> $stable(cur_mask) && $stable(addr_q))
        else $error("fixed burst changed lanes");

    a_narrow_move: assert property ( // R13
        w_fire && cmd_q.burst == BURST_INCR && cmd_q.size < BUS_SIZE &&
        !last_beat |=> cur_mask != $past(cur_mask))
        else $error("narrow incr burst stuck on one lane set");

    a_byte_wires: assert property ( // R15
        w_fire && cmd_q.size == 3'h0 |-> push_beat.data == wdata)
        else $error("byte access moved off its wires");

    a_strb_lanes: assert property ( // R10
        w_fire && !big_endian |-> (push_beat.strb & ~cur_mask) == '0)
        else $error("strobe passed outside addressed lanes");

    a_resp_follow: assert property ( // R6
        w_fire && last_beat |=> bvalid [*1] ##0 !wready)
        else $error("no response after last beat");

    a_strb_flag: assert property ( // R11
        w_fire && ((wstrb & ~cur_mask) != '0) |=> strb_err)
        else $error("stray strobe not flagged");

    a_beat_hold: assert property ( // R10
        beat_valid && !beat_ready |=> beat_valid && $stable(beat))
        else $error("delivered beat changed while stalled");

    a_resp_hold: assert property ( // R5
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("response dropped or changed before taken");

    c_regular_burst: cover property (
        aw_fire && aw_regular && awlen == 8'h03);
    c_wrap_burst: cover property (
        w_fire && last_beat && cmd_q.burst == BURST_WRAP);
    c_fifo_full: cover property (state_q == ST_DATA && !fifo_in_ready);
    c_big_endian: cover property (w_fire && big_endian);
    c_stray_strobe: cover property (strb_err);

endmodule // rtbl_core

`default_nettype wire

/* design/rtbl_fifo.sv */
// Purpose: small FIFO with a registered head word
// Assumes: single clock, valid/ready on both sides
// Notes:   holds DEPTH words in the array plus one in the head register
`timescale 1ns/1ps
`default_nettype none

module rtbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////
    // handshakes: full refuses input, head reloads when free or taken
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = (cnt_q != '0) && (!out_valid || out_ready);

    // storage array
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= PW'(rd_q + 1'b1);
            end
            cnt_q <= (PW+1)'(cnt_q + push - pop);
        end
    end

    // registered head word, so data out never comes from the array
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem_q[rd_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule // rtbl_fifo

`default_nettype wire

/* design/rtbl_pkg.sv */
// Purpose: shared types, constants and lane helpers for the write-side
//          regular-transaction and byte-lane block
// Assumes: 32-bit data bus (4 byte lanes), 32-bit addresses
// Notes:   shared widths, encodings and depths live here; the Regular lengths sit in rtbl_classify
`default_nettype none

package rtbl_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LEN_W = 8;
    localparam int FIFO_DEPTH = 8;

    // bus width as a size code: 4 bytes
    localparam logic [2:0] BUS_SIZE = 3'h2;

    // burst type encodings
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;

    // write response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_RESP = 2'b10
    } rtbl_state_type;

    // address-channel request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LEN_W-1:0] len;
        logic [2:0] size;
        logic [1:0] burst;
    } rtbl_cmd_type;

    // one accepted data beat, as handed to the local side
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] strb;
    } rtbl_beat_type;

    // lanes a beat may use: from the address lane up to the end of
    // the size-aligned slot, so an unaligned first beat is trimmed
    function automatic logic [LANES-1:0] lane_mask(
        input logic [ADDR_W-1:0] addr,
        input logic [2:0] size
    );
        logic [LANES-1:0] slot;
        logic [LANES-1:0] below;
        logic [1:0] base;
        slot = 4'hF;
        base = 2'h0;
        unique case (size)
            3'h0: begin
                slot = 4'h1;
                base = addr[1:0];
            end
            3'h1: begin
                slot = 4'h3;
                base = {addr[1], 1'b0};
            end
            default: begin
                slot = 4'hF;
                base = 2'h0;
            end
        endcase
        below = 4'(({LANES{1'b1}} << addr[1:0]));
        return 4'(slot << base) & below;
    endfunction

    // byte order reversal inside each element of the transfer size
    function automatic logic [DATA_W-1:0] be_swap(
        input logic [DATA_W-1:0] d,
        input logic [2:0] size
    );
        logic [DATA_W-1:0] r;
        r = d;
        if (size == 3'h1) begin
            r = {d[23:16], d[31:24], d[7:0], d[15:8]};
        end else if (size >= BUS_SIZE) begin
            r = {d[7:0], d[15:8], d[23:16], d[31:24]};
        end
        return r;
    endfunction

    // strobe counterpart of be_swap
    function automatic logic [LANES-1:0] be_swap_strb(
        input logic [LANES-1:0] s,
        input logic [2:0] size
    );
        logic [LANES-1:0] r;
        r = s;
        if (size == 3'h1) begin
            r = {s[2], s[3], s[0], s[1]};
        end else if (size >= BUS_SIZE) begin
            r = {s[0], s[1], s[2], s[3]};
        end
        return r;
    endfunction

endpackage

`default_nettype wire
